// ==== pie_gate.sv ====
// Gates each peripheral flag by its enable and the two core enables
// Assumes flags and enables come from logic on the same clock
`timescale 1ns/1ps
module pie_gate
  import pie_pkg::*;
(
  // Inputs
  input wire logic [7:0] flags,
  input wire pie_enable_t enable,
  input wire pie_core_t core,
  // Outputs
  output logic [7:0] pending,
  output logic core_irq
);
  always_comb begin
    pending = flags & enable;
    core_irq = core.global_irq_en & core.peripheral_group_irq_en &
               (|pending);
  end
endmodule // pie_gate

// ==== pie_monitor.sv ====
// Checker for pie_top: bus handshake and interrupt outputs
// Assumes binding to pie_top, one core_clk domain
`timescale 1ns/1ps
module pie_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Interrupts
  input wire logic core_irq_req,
  input wire logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire req = avs_read | avs_write;
  property p_wait; req && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("no answer");
  property p_first; req && !$past(req) |-> avs_waitrequest; endproperty
  a_first: assert property (p_first) else $error("no wait");
  property p_ack; req && !avs_waitrequest |=> !req; endproperty
  a_ack: assert property (p_ack) else $error("double ack");
  property p_rst; $rose(rst_n) |-> !core_irq_req && !irq; endproperty
  a_rst: assert property (p_rst) else $error("irq at reset");
  property p_upper;
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits");
  property p_core; $fell(core_irq_req) |-> $past(avs_write); endproperty
  a_core: assert property (p_core) else $error("request dropped");
  property p_irq; $fell(irq) |-> $past(avs_write); endproperty
  a_irq: assert property (p_irq) else $error("irq dropped");
  c_read: cover property (avs_read && !avs_waitrequest);
  c_core: cover property ($rose(core_irq_req));
  c_irq: cover property ($rose(irq));
endmodule // pie_monitor
bind pie_top pie_monitor pie_monitor_inst (.core_clk(core_clk),
  .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .core_irq_req(core_irq_req), .irq(irq));

// ==== pie_pkg.sv ====
// Package for the peripheral interrupt enable block: offsets, bit layout
// Assumes a 32-bit Avalon-MM slave with word addresses in bytes
package pie_pkg;
  localparam int unsigned PIE_AW = 12;
  localparam logic [PIE_AW-1:0] PIE_ENABLE_OFS = 12'h08c;
  localparam logic [PIE_AW-1:0] PIE_FLAGS_OFS = 12'h00c;
  localparam logic [PIE_AW-1:0] PIE_CORE_CTL_OFS = 12'h00b;
  localparam logic [PIE_AW-1:0] PIE_IRQ_STAT_OFS = 12'h100;
  localparam logic [PIE_AW-1:0] PIE_IRQ_MASK_OFS = 12'h104;
  localparam logic [7:0] PIE_ENABLE_RST = 8'h00;
  localparam logic [7:0] PIE_FLAGS_RST = 8'h00;
  localparam logic [1:0] PIE_CORE_RST = 2'h0;
  localparam int unsigned PIE_BIT_PSP = 7;
  localparam int unsigned PIE_BIT_ADC = 6;
  localparam int unsigned PIE_BIT_RX = 5;
  localparam int unsigned PIE_BIT_TX = 4;
  localparam int unsigned PIE_BIT_SSP = 3;
  localparam int unsigned PIE_BIT_CCP = 2;
  localparam int unsigned PIE_BIT_PRM = 1;
  localparam int unsigned PIE_BIT_OVF = 0;
  localparam int unsigned PIE_BIT_GIE = 7;
  localparam int unsigned PIE_BIT_PERIPHERAL_GROUP_IRQ_EN = 6;
  localparam logic [31:0] PIE_UNMAPPED = 32'h00000000;

  typedef struct packed {
    logic parallel_port_irq_en;
    logic converter_done_irq_en;
    logic serial_rx_irq_en;
    logic serial_tx_irq_en;
    logic sync_serial_irq_en;
    logic capture_compare_irq_en;
    logic period_match_irq_en;
    logic timer_overflow_irq_en;
  } pie_enable_t;

  typedef struct packed {
    logic global_irq_en;
    logic peripheral_group_irq_en;
  } pie_core_t;
endpackage

// ==== pie_top.sv ====
// Peripheral interrupt enable register, flags and core request
// Assumes Avalon-MM master on core_clk; source events are async pins
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
module pie_top
  import pie_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [PIE_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Peripheral events, bit order as enable register
  input wire logic [7:0] source_event,
  // Interrupt outputs
  output logic core_irq_req,
  output logic irq
);
  wire logic [7:0] evt_pulse;
  pie_enable_t peripheral_irq_enable;
  pie_enable_t next_enable;
  logic [7:0] peripheral_irq_flags;
  logic [7:0] next_flags;
  pie_core_t core_irq_control;
  pie_core_t next_core;
  logic [7:0] core_word;
  logic [7:0] irq_status;
  logic [7:0] next_status;
  logic [7:0] irq_mask;
  logic [7:0] next_mask;
  logic bus_req;
  logic ack;
  logic next_ack;
  logic [31:0] read_word;
  logic [31:0] next_rdata;
  logic gate_irq;
  logic [7:0] write_byte;
  logic wr_lo;
  logic wr_enable;
  logic wr_flags;
  logic wr_core;
  logic wr_stat;
  logic wr_mask;

  // Event capture: two-flop synchroniser and edge detect per source
  for (genvar i = 0; i < 8; i++) begin : g_lane
    logic meta;
    logic stable;
    logic prev;
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        meta <= 1'b0;
        stable <= 1'b0;
        prev <= 1'b0;
      end else begin
        meta <= source_event[i];
        stable <= meta;
        prev <= stable;
      end
    end
    assign evt_pulse[i] = stable && !prev;
  end

  // Access decode; a write lands where waitrequest is low
  always_comb begin
    write_byte = avs_writedata[7:0];
    wr_lo = avs_write && ack && avs_byteenable[0];
    wr_enable = wr_lo && (avs_address == PIE_ENABLE_OFS);
    wr_flags = wr_lo && (avs_address == PIE_FLAGS_OFS);
    wr_core = wr_lo && (avs_address == PIE_CORE_CTL_OFS);
    wr_stat = wr_lo && (avs_address == PIE_IRQ_STAT_OFS);
    wr_mask = wr_lo && (avs_address == PIE_IRQ_MASK_OFS);
  end

  // Core enables as seen in the low byte
  always_comb begin
    core_word = '0;
    core_word[PIE_BIT_GIE] = core_irq_control.global_irq_en;
    core_word[PIE_BIT_PERIPHERAL_GROUP_IRQ_EN] = core_irq_control.peripheral_group_irq_en;
  end

  // Read multiplexer, upper bytes read as zero
  always_comb begin
    unique case (avs_address)
      PIE_ENABLE_OFS: read_word = {24'h000000, peripheral_irq_enable};
      PIE_FLAGS_OFS: read_word = {24'h000000, peripheral_irq_flags};
      PIE_CORE_CTL_OFS: read_word = {24'h000000, core_word};
      PIE_IRQ_STAT_OFS: read_word = {24'h000000, irq_status};
      PIE_IRQ_MASK_OFS: read_word = {24'h000000, irq_mask};
      default: read_word = PIE_UNMAPPED;
    endcase
  end

  // Bus handshake: one wait state per transfer
  assign bus_req = avs_read || avs_write;

  always_comb begin
    next_ack = bus_req && !ack;
    next_rdata = avs_readdata;
    if (avs_read && !ack) begin
      next_rdata = read_word;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      avs_readdata <= PIE_UNMAPPED;
    end else begin
      ack <= next_ack;
      avs_readdata <= next_rdata;
    end
  end

  assign avs_waitrequest = bus_req && !ack;

  // Enable register
  always_comb begin
    next_enable = peripheral_irq_enable;
    if (wr_enable) begin
      next_enable = write_byte;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      peripheral_irq_enable <= PIE_ENABLE_RST;
    end else begin
      peripheral_irq_enable <= next_enable;
    end
  end

  // Flags: an event in the cycle of a software write wins
  always_comb begin
    next_flags = peripheral_irq_flags;
    if (wr_flags) begin
      next_flags = write_byte;
    end
    next_flags = next_flags | evt_pulse;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      peripheral_irq_flags <= PIE_FLAGS_RST;
    end else begin
      peripheral_irq_flags <= next_flags;
    end
  end

  // Core enables
  always_comb begin
    next_core = core_irq_control;
    if (wr_core) begin
      next_core.global_irq_en = avs_writedata[PIE_BIT_GIE];
      next_core.peripheral_group_irq_en = avs_writedata[PIE_BIT_PERIPHERAL_GROUP_IRQ_EN];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_irq_control <= PIE_CORE_RST;
    end else begin
      core_irq_control <= next_core;
    end
  end

  // Interrupt mask
  always_comb begin
    next_mask = irq_mask;
    if (wr_mask) begin
      next_mask = write_byte;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= PIE_FLAGS_RST;
    end else begin
      irq_mask <= next_mask;
    end
  end

  // Sticky status, write one to clear; a new event wins
  always_comb begin
    next_status = irq_status;
    if (wr_stat) begin
      next_status = irq_status & ~write_byte;
    end
    next_status = next_status | evt_pulse;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= PIE_FLAGS_RST;
    end else begin
      irq_status <= next_status;
    end
  end

  // Core request gating
  pie_gate pie_gate_inst (
    .flags(peripheral_irq_flags),
    .enable(peripheral_irq_enable),
    .core(core_irq_control),
    .pending(),
    .core_irq(gate_irq)
  );

  // Request towards the core
  always_comb begin
    core_irq_req = gate_irq;
  end

  // Level interrupt from unmasked status
  always_comb begin
    irq = |(irq_status & irq_mask);
  end
endmodule // pie_top

// ==== tb.sv ====
// Testbench for pie_top: registers, gating, interrupt
// Assumes a 50 MHz clock and the one-wait Avalon-MM slave
`timescale 1ns/1ps
module tb;
  import pie_pkg::*;
  logic core_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
  logic avs_waitrequest, core_irq_req, irq;
  logic [PIE_AW-1:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, rd;
  logic [7:0] source_event = 8'h00;
  logic [3:0] avs_byteenable = 4'hf;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  always #10 core_clk = ~core_clk;
  pie_top pie_top_inst (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .source_event(source_event), .core_irq_req(core_irq_req), .irq(irq));
  task automatic complete_run;
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [PIE_AW-1:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic ev(input int b);
    source_event <= 8'h01 << b;
    repeat (6) @(posedge core_clk);
    source_event <= 8'h00;
  endtask
  task automatic t_regs;
    bus(0, PIE_ENABLE_OFS, 0);
    check(rd, 32'h00000000);
    bus(1, PIE_ENABLE_OFS, 32'h000000a5);
    bus(0, PIE_ENABLE_OFS, 0);
    check(rd, 32'h000000a5);
    avs_byteenable <= 4'he;
    bus(1, PIE_ENABLE_OFS, 32'h000000ff);
    avs_byteenable <= 4'hf;
    bus(0, PIE_ENABLE_OFS, 0);
    check(rd, 32'h000000a5);
    bus(1, 12'h200, 32'h000000ff);
    bus(0, 12'h200, 0);
    check(rd, 32'h00000000);
  endtask
  task automatic t_gate;
    for (int b = 0; b < 8; b++) begin
      bus(1, PIE_ENABLE_OFS, 0);
      bus(1, PIE_FLAGS_OFS, 0);
      bus(1, PIE_CORE_CTL_OFS, 32'h00000080);
      ev(b);
      bus(0, PIE_FLAGS_OFS, 0);
      check(rd, 32'h1 << b);
      bus(1, PIE_ENABLE_OFS, 32'h1 << b);
      @(negedge core_clk) check(core_irq_req, 0);
      bus(1, PIE_CORE_CTL_OFS, 32'h000000c0);
      @(negedge core_clk) check(core_irq_req, 1);
      bus(1, PIE_ENABLE_OFS, ~(32'h1 << b) & 32'hff);
      @(negedge core_clk) check(core_irq_req, 0);
    end
  endtask
  task automatic t_irq;
    bus(0, PIE_CORE_CTL_OFS, 0);
    check(rd, 32'h000000c0);
    bus(1, PIE_IRQ_MASK_OFS, 0);
    bus(1, PIE_IRQ_STAT_OFS, 32'h000000ff);
    ev(5);
    @(negedge core_clk) check(irq, 0);
    bus(0, PIE_IRQ_STAT_OFS, 0);
    check(rd, 32'h00000020);
    bus(1, PIE_IRQ_MASK_OFS, 32'h00000020);
    @(negedge core_clk) check(irq, 1);
    bus(1, PIE_IRQ_STAT_OFS, 32'h00000020);
    @(negedge core_clk) check(irq, 0);
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_gate();
    t_irq();
    complete_run();
  end
endmodule // tb
